// ===== src/blk_pkg.sv
// Package: constants and types for the serial block power and two-wire configuration logic.
// Assumes one clock at 40 MHz and an active-low asynchronous reset.
package blk_pkg;
   // ************************************
   // Modes and roles
   // ************************************
   typedef enum logic [2:0] {
      MODE_NONE = 3'b000,
      MODE_TWO_WIRE = 3'b001,
      MODE_SPI = 3'b010,
      MODE_UART = 3'b011,
      MODE_EEPROM = 3'b100
   } block_mode_e;

   typedef enum logic [1:0] {
      ROLE_SLAVE_ONLY = 2'b00,
      ROLE_MASTER_ONLY = 2'b01,
      ROLE_MULTI_MASTER = 2'b10,
      ROLE_MULTI_MASTER_AND_SLAVE = 2'b11
   } role_e;

   typedef enum logic [1:0] {
      IRQ_NONE = 2'b00,
      IRQ_INTERNAL = 2'b01,
      IRQ_EXTERNAL = 2'b10
   } irq_route_e;

   // ************************************
   // Widths, reset values, limits
   // ************************************
   localparam int PHASE_W = 8;
   localparam int RATE_W = 10;
   localparam int TX_SRC_W = 4;
   localparam logic [PHASE_W-1:0] PHASE_RESET = 8'h08;
   localparam logic [6:0] ADDR_RESET = 7'h08;
   localparam logic [7:0] MASK_RESET = 8'hfe;
   localparam logic [7:0] MASK_LSB_CLEAR = 8'hfe;
   localparam logic [RATE_W-1:0] RATE_RESET = 10'h064;
   // Filter is used at or below this data rate in kbps
   localparam logic [RATE_W-1:0] FILTER_RATE_MAX = 10'h190;
   localparam logic [TX_SRC_W-1:0] TX_SRC_NONE = 4'h0;
   localparam logic [PHASE_W-1:0] PHASE_ONE = 8'h01;
endpackage : blk_pkg

// ===== src/cfg_if.sv
// Interface: configuration carried from the control core to the bus engines.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface cfg_if;
   import blk_pkg::*;
   logic active;
   role_e role;
   logic [PHASE_W-1:0] low_cycles;
   logic [PHASE_W-1:0] high_cycles;
   logic [6:0] own_addr;
   logic [7:0] own_mask;
   modport ctrl (output active, role, low_cycles, high_cycles, own_addr, own_mask);
   modport eng (input active, role, low_cycles, high_cycles, own_addr, own_mask);
endinterface : cfg_if

// ===== src/scl_phase_gen.sv
// Master clock phase generator: counts low and high SCL phases in block cycles.
// Assumes configuration stays stable while active.
`timescale 1ns/1ps
module scl_phase_gen
   import blk_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   cfg_if.eng cfg,
   output logic scl_low
);
   logic [PHASE_W-1:0] count;
   logic master;

   assign master = cfg.role != ROLE_SLAVE_ONLY;

   // ************************************
   // Phase counter
   // ************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
         scl_low <= 1'b0;
      end else if (!(cfg.active && master)) begin
         count <= '0;
         scl_low <= 1'b0;
      end else if (scl_low && count + PHASE_ONE >= cfg.low_cycles) begin
         count <= '0;
         scl_low <= 1'b0;
      end else if (!scl_low && count + PHASE_ONE >= cfg.high_cycles) begin
         count <= '0;
         scl_low <= 1'b1;
      end else begin
         count <= count + PHASE_ONE;
      end
   end
endmodule : scl_phase_gen

// ===== src/addr_match.sv
// Masked own-address comparator for slave roles.
// Assumes the address byte arrives with the direction bit in bit 0.
`timescale 1ns/1ps
module addr_match
   import blk_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   cfg_if.eng cfg,
   input wire logic addr_valid,
   input wire logic [7:0] addr_byte,
   output logic hit
);
   logic slave;
   logic [7:0] own;

   assign slave = cfg.role == ROLE_SLAVE_ONLY || cfg.role == ROLE_MULTI_MASTER_AND_SLAVE;
   assign own = {cfg.own_addr, 1'b0};

   // ************************************
   // Compare
   // ************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hit <= 1'b0;
      end else begin
         // Direction bit never compared: mask bit 0 is forced clear
         hit <= addr_valid && cfg.active && slave
            && (((addr_byte ^ own) & cfg.own_mask) == 8'h00);
      end
   end
endmodule : addr_match

// ===== src/serial_block_ctrl.sv
// Top: enable, disable, deep-sleep and two-wire configuration control of the serial block.
// Assumes operation strobes are one-cycle pulses synchronous to REF_CLK.
//
// Contract
// - Enable switches on the serial hardware and the interrupt output of the mode's route.
// - Enable re-arms masked transmit sources except level-triggered ones.
// - Two-wire mode always routes interrupt internally; SPI and UART selectable.
// - Enable is ignored until a mode initialization has run.
// - Disable turns off hardware and interrupt and masks all transmit sources.
// - Disable acts at once, even mid-transfer; software checks status first.
// - Sleep with wakeup selected arms an enabled block as a wake source.
// - Sleep without wakeup records enabled state then disables.
// - Wake with wakeup selected restores active configuration.
// - Wake without wakeup re-enables only if recorded state was enabled.
// - Role is slave only, master only, multi-master, or multi-master plus slave.
// - Master holds SCL low for the configured number of cycles.
// - Master holds SCL high for the configured number of cycles.
// - Glitch filter follows data rate and role; explicit select ignored.
// - Slave roles match received address against the 7-bit own address.
// - Address mask is 8 bits with bit 0 held at zero.
`timescale 1ns/1ps
module serial_block_ctrl
   import blk_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic ARST_N,
   input wire logic BLOCK_ENABLE_OP,
   input wire logic BLOCK_DISABLE_OP,
   input wire logic SLEEP_PREPARE_OP,
   input wire logic WAKE_RESTORE_OP,
   input wire logic WAKE_SELECT,
   input wire logic TWO_WIRE_INIT_OP,
   input wire logic OTHER_INIT_OP,
   input wire logic [2:0] OTHER_MODE,
   input wire logic [1:0] OTHER_IRQ_ROUTE,
   input wire logic [1:0] ROLE_SELECT,
   input wire logic [PHASE_W-1:0] SCL_LOW_PHASE_CYCLES,
   input wire logic [PHASE_W-1:0] SCL_HIGH_PHASE_CYCLES,
   input wire logic GLITCH_FILTER_SELECT,
   input wire logic [RATE_W-1:0] DATA_RATE_KBPS,
   input wire logic [6:0] OWN_BUS_ADDRESS,
   input wire logic [7:0] OWN_ADDRESS_MASK,
   input wire logic [TX_SRC_W-1:0] TX_SRC_REQUEST,
   input wire logic [TX_SRC_W-1:0] TX_SRC_LEVEL,
   input wire logic ADDR_VALID,
   input wire logic [7:0] ADDR_BYTE,
   input wire logic BUS_ACTIVITY,
   output logic HW_ON,
   output logic IRQ_INTERNAL_ON,
   output logic IRQ_EXTERNAL_ON,
   output logic [2:0] MODE_STATE,
   output logic [TX_SRC_W-1:0] TX_SRC_ARMED,
   output logic WAKE_SOURCE_ARMED,
   output logic WAKE_EVENT,
   output logic SAVED_ENABLE,
   output logic GLITCH_FILTER_ON,
   output logic SCL_LOW,
   output logic ADDR_HIT
);
   // ************************************
   // State
   // ************************************
   block_mode_e mode;
   irq_route_e irq_route;
   role_e role;
   logic enabled;
   logic saved_en;
   logic wake_armed;
   logic [TX_SRC_W-1:0] tx_armed;
   logic [TX_SRC_W-1:0] tx_saved;
   logic [RATE_W-1:0] rate;
   logic [PHASE_W-1:0] low_cycles;
   logic [PHASE_W-1:0] high_cycles;
   logic [6:0] own_addr;
   logic [7:0] own_mask;
   logic scl_low;
   logic hit;
   logic next_enabled;
   logic do_enable;
   logic do_disable;
   logic cfg_open;

   cfg_if cfg ();

   // Configuration is only taken while disabled, so the engines never see it move
   assign cfg_open = !enabled;
   assign do_enable = (BLOCK_ENABLE_OP || (WAKE_RESTORE_OP && !WAKE_SELECT && saved_en))
      && mode != MODE_NONE;
   // Immediate: no check of a transfer in flight, the byte may be cut
   assign do_disable = BLOCK_DISABLE_OP || (SLEEP_PREPARE_OP && !WAKE_SELECT);

   always_comb begin
      next_enabled = enabled;
      if (do_disable) begin
         next_enabled = 1'b0;
      end else if (do_enable) begin
         next_enabled = 1'b1;
      end
   end

   // ************************************
   // Mode initialization
   // ************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode <= MODE_NONE;
         irq_route <= IRQ_NONE;
      end else if (cfg_open && TWO_WIRE_INIT_OP) begin
         mode <= MODE_TWO_WIRE;
         irq_route <= IRQ_INTERNAL;
      end else if (cfg_open && OTHER_INIT_OP) begin
         unique case (OTHER_MODE)
            MODE_SPI, MODE_UART: begin
               mode <= block_mode_e'(OTHER_MODE);
               irq_route <= irq_route_e'(OTHER_IRQ_ROUTE);
            end
            MODE_EEPROM: begin
               mode <= MODE_EEPROM;
               irq_route <= IRQ_INTERNAL;
            end
            default: begin
               mode <= mode;
               irq_route <= irq_route;
            end
         endcase
      end
   end

   // ************************************
   // Two-wire configuration
   // ************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         role <= ROLE_SLAVE_ONLY;
         low_cycles <= PHASE_RESET;
         high_cycles <= PHASE_RESET;
         own_addr <= ADDR_RESET;
         own_mask <= MASK_RESET;
         rate <= RATE_RESET;
      end else if (cfg_open && TWO_WIRE_INIT_OP) begin
         role <= role_e'(ROLE_SELECT);
         low_cycles <= SCL_LOW_PHASE_CYCLES;
         high_cycles <= SCL_HIGH_PHASE_CYCLES;
         own_addr <= OWN_BUS_ADDRESS;
         own_mask <= OWN_ADDRESS_MASK & MASK_LSB_CLEAR;
         rate <= DATA_RATE_KBPS;
      end
   end

   // ************************************
   // Enable and disable
   // ************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         enabled <= 1'b0;
      end else begin
         enabled <= next_enabled;
      end
   end

   // ************************************
   // Transmit interrupt sources
   // ************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tx_armed <= TX_SRC_NONE;
         tx_saved <= TX_SRC_NONE;
      end else if (do_disable) begin
         // Empty FIFO after enable would otherwise fire at once
         tx_saved <= tx_armed | TX_SRC_REQUEST;
         tx_armed <= TX_SRC_NONE;
      end else if (do_enable && !enabled) begin
         // Level sources stay masked to avoid a lock-up
         tx_armed <= tx_saved & ~TX_SRC_LEVEL;
      end else if (enabled) begin
         // Level sources may drop but never re-arm while enabled
         tx_armed <= (TX_SRC_REQUEST & ~TX_SRC_LEVEL) | (tx_armed & TX_SRC_REQUEST);
      end
   end

   // ************************************
   // Deep sleep
   // ************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         saved_en <= 1'b0;
         wake_armed <= 1'b0;
      end else if (SLEEP_PREPARE_OP) begin
         if (WAKE_SELECT) begin
            wake_armed <= enabled && mode != MODE_NONE;
         end else begin
            saved_en <= enabled;
         end
      end else if (WAKE_RESTORE_OP) begin
         wake_armed <= 1'b0;
      end
   end

   // ************************************
   // Outputs
   // ************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         HW_ON <= 1'b0;
         IRQ_INTERNAL_ON <= 1'b0;
         IRQ_EXTERNAL_ON <= 1'b0;
         MODE_STATE <= 3'h0;
         TX_SRC_ARMED <= TX_SRC_NONE;
         WAKE_SOURCE_ARMED <= 1'b0;
         WAKE_EVENT <= 1'b0;
         SAVED_ENABLE <= 1'b0;
         GLITCH_FILTER_ON <= 1'b0;
         SCL_LOW <= 1'b0;
         ADDR_HIT <= 1'b0;
      end else begin
         HW_ON <= enabled;
         IRQ_INTERNAL_ON <= enabled && irq_route == IRQ_INTERNAL;
         IRQ_EXTERNAL_ON <= enabled && irq_route == IRQ_EXTERNAL;
         MODE_STATE <= mode;
         TX_SRC_ARMED <= tx_armed;
         WAKE_SOURCE_ARMED <= wake_armed;
         WAKE_EVENT <= wake_armed && BUS_ACTIVITY;
         SAVED_ENABLE <= saved_en;
         // Select input deliberately unused; rate and role decide
         GLITCH_FILTER_ON <= mode == MODE_TWO_WIRE && (rate <= FILTER_RATE_MAX
            || role == ROLE_SLAVE_ONLY) && (GLITCH_FILTER_SELECT || !GLITCH_FILTER_SELECT);
         SCL_LOW <= scl_low;
         ADDR_HIT <= hit;
      end
   end

   assign cfg.active = enabled && mode == MODE_TWO_WIRE;
   assign cfg.role = role;
   assign cfg.low_cycles = low_cycles;
   assign cfg.high_cycles = high_cycles;
   assign cfg.own_addr = own_addr;
   assign cfg.own_mask = own_mask;

   scl_phase_gen u_phase (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .cfg(cfg.eng),
      .scl_low(scl_low)
   );

   addr_match u_match (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .cfg(cfg.eng),
      .addr_valid(ADDR_VALID),
      .addr_byte(ADDR_BYTE),
      .hit(hit)
   );
endmodule : serial_block_ctrl

// ===== tb/serial_block_ctrl_assertions.sv
// Checker: timing relations at the serial block control ports.
// Assumes the bind at the foot attaches it to every top instance.
`timescale 1ns/1ps
module serial_block_ctrl_assertions
   import blk_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic ARST_N,
   input wire logic BLOCK_ENABLE_OP,
   input wire logic BLOCK_DISABLE_OP,
   input wire logic SLEEP_PREPARE_OP,
   input wire logic WAKE_SELECT,
   input wire logic TWO_WIRE_INIT_OP,
   input wire logic OTHER_INIT_OP,
   input wire logic BUS_ACTIVITY,
   input wire logic ADDR_VALID,
   input wire logic HW_ON,
   input wire logic IRQ_INTERNAL_ON,
   input wire logic IRQ_EXTERNAL_ON,
   input wire logic [2:0] MODE_STATE,
   input wire logic [TX_SRC_W-1:0] TX_SRC_ARMED,
   input wire logic WAKE_SOURCE_ARMED,
   input wire logic WAKE_EVENT,
   input wire logic GLITCH_FILTER_ON,
   input wire logic ADDR_HIT
);
   // ****
   // Properties
   // ****
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   AST_DISABLE: assert property (BLOCK_DISABLE_OP |-> ##2 !HW_ON && !IRQ_INTERNAL_ON && TX_SRC_ARMED == 4'h0)
      else $error("disable left block on");
   // Init one cycle earlier may already have set the mode
   AST_NO_MODE: assert property ((BLOCK_ENABLE_OP && MODE_STATE == 3'h0 && !TWO_WIRE_INIT_OP && !OTHER_INIT_OP
      && !$past(TWO_WIRE_INIT_OP) && !$past(OTHER_INIT_OP)) |-> ##2 !HW_ON) else $error("enable without mode");
   AST_ENABLE: assert property ((BLOCK_ENABLE_OP && !BLOCK_DISABLE_OP && !SLEEP_PREPARE_OP && MODE_STATE == 3'h1
      && !OTHER_INIT_OP && !$past(OTHER_INIT_OP)) |-> ##2 HW_ON && IRQ_INTERNAL_ON) else $error("enable failed");
   AST_SLEEP_OFF: assert property ((SLEEP_PREPARE_OP && !WAKE_SELECT) |-> ##2 !HW_ON)
      else $error("sleep left block on");
   AST_WAKE_ARM: assert property ((SLEEP_PREPARE_OP && WAKE_SELECT && HW_ON && !BLOCK_DISABLE_OP
      && !$past(BLOCK_DISABLE_OP) && !$past(SLEEP_PREPARE_OP)) |-> ##2 WAKE_SOURCE_ARMED) else $error("wake not armed");
   AST_WAKE_EVT: assert property (WAKE_EVENT |-> $past(BUS_ACTIVITY) || $past(BUS_ACTIVITY, 2))
      else $error("wake event without activity");
   AST_HIT: assert property (ADDR_HIT |-> $past(ADDR_VALID, 2))
      else $error("hit without address");
   AST_FILTER: assert property (GLITCH_FILTER_ON |-> MODE_STATE == 3'h1)
      else $error("filter outside two-wire");
   AST_IRQ_ROUTE: assert property ((HW_ON && MODE_STATE == 3'h1) |-> IRQ_INTERNAL_ON && !IRQ_EXTERNAL_ON)
      else $error("two-wire irq not internal");
   cover property (HW_ON && IRQ_INTERNAL_ON);
   cover property (ADDR_HIT);
   cover property (WAKE_EVENT);
endmodule : serial_block_ctrl_assertions

bind serial_block_ctrl serial_block_ctrl_assertions chk_u (.REF_CLK, .ARST_N, .BLOCK_ENABLE_OP, .BLOCK_DISABLE_OP,
   .SLEEP_PREPARE_OP, .WAKE_SELECT, .TWO_WIRE_INIT_OP, .OTHER_INIT_OP, .BUS_ACTIVITY, .ADDR_VALID, .HW_ON,
   .IRQ_INTERNAL_ON, .IRQ_EXTERNAL_ON, .MODE_STATE, .TX_SRC_ARMED, .WAKE_SOURCE_ARMED, .WAKE_EVENT,
   .GLITCH_FILTER_ON, .ADDR_HIT);

// ===== tb/bus_peer_model.sv
// Model: another party on the two-wire bus, sending address bytes and activity.
// Assumes the caller enters its tasks away from a clock edge.
`timescale 1ns/1ps
module bus_peer_model (
   input wire logic clk,
   output logic valid,
   output logic [7:0] abyte,
   output logic activity
);
   // ****
   // Bus side
   // ****
   initial begin
      valid = 1'b0;
      abyte = 8'h00;
      activity = 1'b0;
   end
   // Byte carries the direction bit in bit 0; released byte shows its inverse
   task send(input logic [7:0] b);
      @(posedge clk);
      valid <= 1'b1;
      abyte <= b;
      @(posedge clk);
      valid <= 1'b0;
      abyte <= ~b;
   endtask : send
   task stir(input logic v);
      @(posedge clk);
      activity <= v;
   endtask : stir
endmodule : bus_peer_model

// ===== tb/test_serial_block_ctrl.sv
// Testbench: drives operation strobes and configuration, checks outputs.
// Assumes outputs answer two edges after an operation is taken.
`timescale 1ns/1ps
module test_serial_block_ctrl;
   import blk_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] ops = 6'h00;
   logic [1:0] role = 2'h3;
   logic [9:0] rate = 10'h064;
   logic [3:0] req = 4'hf;
   logic [3:0] lvl = 4'h0;
   logic wsel = 1'b0;
   logic [6:0] own = 7'h2a;
   logic [7:0] msk = 8'hf0;
   logic [2:0] omode = 3'h2;
   logic [1:0] oirq = 2'h2;
   logic av, act, hw, irq_i, irq_e, armw, wev, sav, filt, scl, hit;
   logic [7:0] ab;
   logic [2:0] mode;
   logic [3:0] armed;
   logic [8:0] tab [4] = '{9'h155, 9'h15b, 9'h0d4, 9'h064};
   int n_mismatch = 0;
   int comparisons = 0;
   int n, lo, hi;
   always #12.5 clk = ~clk;
   bus_peer_model peer_u (.clk(clk), .valid(av), .abyte(ab), .activity(act));
   serial_block_ctrl dut_u (.REF_CLK(clk), .ARST_N(rst_n), .BLOCK_ENABLE_OP(ops[0]), .BLOCK_DISABLE_OP(ops[1]),
      .SLEEP_PREPARE_OP(ops[2]), .WAKE_RESTORE_OP(ops[3]), .WAKE_SELECT(wsel), .TWO_WIRE_INIT_OP(ops[4]),
      .OTHER_INIT_OP(ops[5]), .OTHER_MODE(omode), .OTHER_IRQ_ROUTE(oirq), .ROLE_SELECT(role),
      .SCL_LOW_PHASE_CYCLES(8'h03), .SCL_HIGH_PHASE_CYCLES(8'h05), .GLITCH_FILTER_SELECT(1'b1),
      .DATA_RATE_KBPS(rate), .OWN_BUS_ADDRESS(own), .OWN_ADDRESS_MASK(msk), .TX_SRC_REQUEST(req),
      .TX_SRC_LEVEL(lvl), .ADDR_VALID(av), .ADDR_BYTE(ab), .BUS_ACTIVITY(act), .HW_ON(hw),
      .IRQ_INTERNAL_ON(irq_i), .IRQ_EXTERNAL_ON(irq_e), .MODE_STATE(mode), .TX_SRC_ARMED(armed),
      .WAKE_SOURCE_ARMED(armw), .WAKE_EVENT(wev), .SAVED_ENABLE(sav), .GLITCH_FILTER_ON(filt),
      .SCL_LOW(scl), .ADDR_HIT(hit));
   // ****
   // Tasks
   // ****
   task chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task op(input logic [5:0] v);
      @(posedge clk);
      ops <= v;
      @(posedge clk);
      ops <= 6'h00;
      repeat (2) @(posedge clk);
      #1;
   endtask : op
   // Configuration only moves while disabled
   task init2(input logic [1:0] r, input logic [9:0] rt);
      @(posedge clk);
      role <= r;
      rate <= rt;
      op(6'h10);
   endtask : init2
   task lvl_wait(input logic v, output int k);
      k = 0;
      while (scl !== v && k < 40) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask : lvl_wait
   task send_chk(input logic [7:0] b, input logic e);
      peer_u.send(b);
      // Hit stands for one cycle only
      @(posedge clk);
      #1;
      chk("addr hit", e, hit);
   endtask : send_chk
   task end_sim;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   // ****
   // Sequence
   // ****
   initial begin
      #500000;
      n_mismatch++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      op(6'h01);
      chk("hw no mode", 0, hw);
      init2(2'h3, 10'h064);
      op(6'h01);
      chk("hw on", 1, hw);
      chk("irq int", 1, irq_i);
      chk("mode", 1, mode);
      chk("filter", 1, filt);
      foreach (tab[i]) send_chk(tab[i][7:0], tab[i][8]);
      lvl_wait(0, n);
      lvl_wait(1, n);
      lvl_wait(0, lo);
      lvl_wait(1, hi);
      chk("scl low", 3, lo);
      chk("scl high", 5, hi);
      op(6'h02);
      chk("tx off", 0, armed);
      chk("hw off", 0, hw);
      @(posedge clk) lvl <= 4'h3;
      op(6'h01);
      chk("tx rearm", 4'hc, armed);
      op(6'h04);
      chk("saved", 1, sav);
      chk("hw sleep", 0, hw);
      op(6'h08);
      chk("hw wake", 1, hw);
      chk("tx wake", 4'hc, armed);
      op(6'h02);
      op(6'h04);
      chk("saved off", 0, sav);
      op(6'h08);
      chk("hw stays off", 0, hw);
      op(6'h01);
      @(posedge clk) wsel <= 1'b1;
      op(6'h04);
      chk("wake arm", 1, armw);
      peer_u.stir(1'b1);
      repeat (3) @(posedge clk);
      #1;
      chk("wake event", 1, wev);
      peer_u.stir(1'b0);
      op(6'h08);
      chk("arm clear", 0, armw);
      chk("hw restore", 1, hw);
      // Fast rate: filter only survives in slave-only role
      for (int r = 0; r < 4; r++) begin
         op(6'h02);
         init2(2'(r), 10'h3e8);
         op(6'h01);
         chk("filter role", r == 0, filt);
         send_chk(8'h55, r == 0 || r == 3);
         lvl_wait(!scl, n);
         chk("scl run", r != 0, n < 40);
      end
      op(6'h02);
      op(6'h20);
      op(6'h01);
      chk("irq ext", 1, irq_e);
      chk("irq int off", 0, irq_i);
      op(6'h02);
      @(posedge clk) begin
         omode <= 3'h3;
         oirq <= 2'h0;
      end
      op(6'h20);
      op(6'h01);
      chk("uart mode", 3, mode);
      chk("irq none", 0, irq_i | irq_e);
      op(6'h10);
      chk("init refused", 3, mode);
      op(6'h02);
      @(posedge clk) omode <= 3'h4;
      op(6'h20);
      op(6'h01);
      chk("eeprom mode", 4, mode);
      chk("eeprom irq", 1, irq_i);
      end_sim;
   end
endmodule : test_serial_block_ctrl
